//--- logic/pue_pkg.sv
// Constants and types for power-up sequencing and input lockout
// Notes on behaviour
// - Start power-up only with a valid supply and the enable input high.
// - Power-up done is shown by driving the active-low alert output low.
// - Enable input low keeps the block in Off mode, all start-up stopped.
// - Four-bit lockout code selects 4.5V to 8.5V in 0.4V steps.
// - Lockout code is 7.3V after power-up, rewritable any time while operating.
// - Supply below the lockout level keeps the buck-boost controller off.
// - Undervoltage locks out the converter only after persisting for 150us blanking.
// - Alert output is open-drain, active low, signalling a pending alert.
`default_nettype none

package pue_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BLANK_TIME_NS = 150000;
  // Least time, rounded up to whole cycles
  localparam int unsigned BLANK_CYCLES =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CNT_W = 15;
  // Settling time between enable qualified and power-up done
  localparam int unsigned START_CYCLES = 16;
  localparam int unsigned START_CNT_W = 5;

  // ----------------------------------------------------------------
  // Lockout level coding
  // ----------------------------------------------------------------
  localparam int unsigned LEVEL_W = 4;
  localparam int unsigned LEVEL_MV_W = 14;
  localparam logic [13:0] LEVEL_BASE_MV = 14'h1194;
  localparam logic [13:0] LEVEL_STEP_MV = 14'h0190;
  localparam logic [13:0] LEVEL_DEFAULT_MV = 14'h1c84;
  localparam logic [3:0] LEVEL_MAX_CODE = 4'ha;
  localparam logic [3:0] LEVEL_DEFAULT_CODE = 4'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAIT_SUPPLY,
    ST_STARTING,
    ST_READY
  } pue_state_t;

  typedef struct packed {
    logic off_mode;
    logic starting;
    logic powered_up;
    logic lockout;
  } pue_status_t;

endpackage : pue_pkg

`default_nettype wire

//--- logic/pue_sync3.sv
// Three-stage input synchroniser with agreement filter
`default_nettype none

module pue_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous level in
  input wire logic i_async,
  // Filtered level out
  output logic o_level
);

  logic ff1;
  logic ff2;
  logic ff3;
  wire agree = (ff2 == ff3);

  // Shift chain; output follows once the last two stages agree
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      o_level <= RESET_VAL;
    end
    else
    begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
      if (agree)
        o_level <= ff3;
    end
  end

endmodule : pue_sync3

`default_nettype wire

//--- logic/pue_top.sv
// Power-up sequencer with programmable input undervoltage lockout
`default_nettype none

module pue_top #(
  parameter int unsigned BLANK_CYCLES = pue_pkg::BLANK_CYCLES
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Pins and analog comparator results
  input wire logic I_HIGH_VOLTAGE_ENABLE_IN,
  input wire logic I_SUPPLY_VALID,
  input wire logic I_SUPPLY_BELOW_LEVEL,
  // Lockout level write from the serial interface logic
  input wire logic I_LEVEL_WR,
  input wire logic [3:0] I_LEVEL_WDATA,
  // Alert acknowledge from the serial interface logic
  input wire logic I_ALERT_CLEAR,
  // Buck-boost run request from the converter control logic
  input wire logic I_CONVERTER_REQ,
  // Open-drain alert pin
  output logic O_ALERT_OUT,
  output logic O_ALERT_OE,
  // Lockout level to the comparator
  output logic [3:0] O_INPUT_LOCKOUT_LEVEL,
  output logic [13:0] O_LOCKOUT_MV,
  // Converter gate
  output logic O_CONVERTER_EN,
  // Status
  output pue_pkg::pue_status_t O_STATUS
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic enable_in;
  logic supply_ok;
  logic below_level;

  // Enable pin
  pue_sync3 #(.RESET_VAL(1'b0)) u_sync_enable (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(I_HIGH_VOLTAGE_ENABLE_IN),
    .o_level(enable_in)
  );

  // Supply valid comparator
  pue_sync3 #(.RESET_VAL(1'b0)) u_sync_supply (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(I_SUPPLY_VALID),
    .o_level(supply_ok)
  );

  // Lockout comparator, assumed below at reset
  pue_sync3 #(.RESET_VAL(1'b1)) u_sync_below (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(I_SUPPLY_BELOW_LEVEL),
    .o_level(below_level)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  pue_pkg::pue_state_t state;
  pue_pkg::pue_state_t next_state;
  logic [pue_pkg::START_CNT_W-1:0] start_cnt;
  logic [pue_pkg::BLANK_CNT_W-1:0] blank_cnt;
  logic lockout;
  logic alert_pending;
  logic [3:0] level;

  // Start condition: valid supply, above level, enable high
  wire start_ok = enable_in & supply_ok & ~below_level;
  wire start_done = (start_cnt ==
    pue_pkg::START_CNT_W'(pue_pkg::START_CYCLES - 1));
  // Entry to ready only when the decode really moves there (enable still high)
  wire enter_ready = (state == pue_pkg::ST_STARTING) & (next_state == pue_pkg::ST_READY);
  wire in_off = (state == pue_pkg::ST_OFF);

  // Next state decode
  always_comb
  begin
    next_state = state;
    if (!enable_in)
      next_state = pue_pkg::ST_OFF;
    else
    begin
      case (state)
        pue_pkg::ST_OFF:
          next_state = pue_pkg::ST_WAIT_SUPPLY;
        pue_pkg::ST_WAIT_SUPPLY:
          if (start_ok)
            next_state = pue_pkg::ST_STARTING;
        pue_pkg::ST_STARTING:
          if (!start_ok)
            next_state = pue_pkg::ST_WAIT_SUPPLY;
          else if (start_done)
            next_state = pue_pkg::ST_READY;
        pue_pkg::ST_READY:
          if (!supply_ok)
            next_state = pue_pkg::ST_WAIT_SUPPLY;
        default:
          next_state = pue_pkg::ST_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      state <= pue_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // Start-up settling counter, cleared outside the starting state
  wire [pue_pkg::START_CNT_W-1:0] next_start_cnt =
    (state == pue_pkg::ST_STARTING && !start_done) ?
    start_cnt + pue_pkg::START_CNT_W'(1) : '0;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      start_cnt <= '0;
    else
      start_cnt <= next_start_cnt;
  end

  // ----------------------------------------------------------------
  // Lockout level register
  // ----------------------------------------------------------------
  // Codes above the top step saturate at the top level
  wire [3:0] wr_code = (I_LEVEL_WDATA > pue_pkg::LEVEL_MAX_CODE) ?
    pue_pkg::LEVEL_MAX_CODE : I_LEVEL_WDATA;
  wire [3:0] next_level = in_off ? pue_pkg::LEVEL_DEFAULT_CODE :
    (I_LEVEL_WR ? wr_code : level);
  // Threshold in millivolts: base plus code times step
  wire [13:0] next_mv = pue_pkg::LEVEL_BASE_MV +
    14'(next_level * pue_pkg::LEVEL_STEP_MV);

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      level <= pue_pkg::LEVEL_DEFAULT_CODE;
      O_LOCKOUT_MV <= pue_pkg::LEVEL_DEFAULT_MV;
    end
    else
    begin
      level <= next_level;
      O_LOCKOUT_MV <= next_mv;
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage blanking
  // ----------------------------------------------------------------
  // Count while below; any return above restarts the count
  wire blank_end = (blank_cnt == pue_pkg::BLANK_CNT_W'(BLANK_CYCLES - 1));
  wire [pue_pkg::BLANK_CNT_W-1:0] next_blank_cnt =
    (!below_level || in_off) ? '0 :
    (blank_end ? blank_cnt : blank_cnt + pue_pkg::BLANK_CNT_W'(1));
  wire next_lockout = below_level & ~in_off & (blank_end | lockout);

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      blank_cnt <= '0;
      lockout <= 1'b0;
    end
    else
    begin
      blank_cnt <= next_blank_cnt;
      lockout <= next_lockout;
    end
  end

  // ----------------------------------------------------------------
  // Converter gate
  // ----------------------------------------------------------------
  wire next_conv_en = I_CONVERTER_REQ & (state == pue_pkg::ST_READY) &
    ~next_lockout;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      O_CONVERTER_EN <= 1'b0;
    else
      O_CONVERTER_EN <= next_conv_en;
  end

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  // Set on power-up done; set wins over a clear in the same cycle
  wire next_alert = ~in_off & (enter_ready | (alert_pending & ~I_ALERT_CLEAR));

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      alert_pending <= 1'b0;
      O_ALERT_OE <= 1'b0;
      O_ALERT_OUT <= 1'b0;
    end
    else
    begin
      alert_pending <= next_alert;
      O_ALERT_OE <= next_alert;
      O_ALERT_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  pue_pkg::pue_status_t next_status;
  assign next_status.off_mode = (next_state == pue_pkg::ST_OFF);
  assign next_status.starting = (next_state == pue_pkg::ST_STARTING);
  assign next_status.powered_up = (next_state == pue_pkg::ST_READY);
  assign next_status.lockout = next_lockout;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_STATUS <= '{off_mode: 1'b1, starting: 1'b0, powered_up: 1'b0, lockout: 1'b0};
      O_INPUT_LOCKOUT_LEVEL <= pue_pkg::LEVEL_DEFAULT_CODE;
    end
    else
    begin
      O_STATUS <= next_status;
      O_INPUT_LOCKOUT_LEVEL <= next_level;
    end
  end

endmodule : pue_top

`default_nettype wire

//--- bench/pue_master_model.sv
// Serial-master side model: lockout level writes and alert acknowledge
`default_nettype none

module pue_master_model (
  // Clock
  input wire logic i_clk,
  // Requests into the block
  output logic o_level_wr,
  output logic [3:0] o_level_wdata,
  output logic o_alert_clear
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels at time zero
  initial
  begin
    o_level_wr = 1'b0;
    o_level_wdata = 4'h0;
    o_alert_clear = 1'b0;
  end

  // One-cycle write; data then shows the inverse so stale values never match
  task write_level(input logic [3:0] code);
    @(posedge i_clk);
    #1;
    o_level_wr = 1'b1;
    o_level_wdata = code;
    @(posedge i_clk);
    #1;
    o_level_wr = 1'b0;
    o_level_wdata = ~code;
  endtask : write_level

  // One-cycle acknowledge
  task clear_alert;
    @(posedge i_clk);
    #1;
    o_alert_clear = 1'b1;
    @(posedge i_clk);
    #1;
    o_alert_clear = 1'b0;
  endtask : clear_alert
endmodule : pue_master_model

`default_nettype wire

//--- bench/pue_top_sva.sv
// Port checker for the power-up sequencer
`default_nettype none

module pue_top_sva #(
  parameter int unsigned BLANK_CYCLES = pue_pkg::BLANK_CYCLES
) (
  // Clock, reset and inputs
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_SUPPLY_BELOW_LEVEL,
  input wire logic I_LEVEL_WR,
  input wire logic [3:0] I_LEVEL_WDATA,
  input wire logic I_ALERT_CLEAR,
  input wire logic I_CONVERTER_REQ,
  // Outputs
  input wire logic O_ALERT_OUT,
  input wire logic O_ALERT_OE,
  input wire logic [3:0] O_INPUT_LOCKOUT_LEVEL,
  input wire logic [13:0] O_LOCKOUT_MV,
  input wire logic O_CONVERTER_EN,
  input wire pue_pkg::pue_status_t O_STATUS
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  // Run length of the raw undervoltage input
  logic [15:0] below_run;
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST) below_run <= 16'h0000;
    else if (!I_SUPPLY_BELOW_LEVEL) below_run <= 16'h0000;
    else if (below_run != 16'hffff) below_run <= below_run + 16'h0001;
  end

  // Taken write followed by a non-Off cycle
  sequence s_wr;
    I_LEVEL_WR && !O_STATUS.off_mode ##1 !O_STATUS.off_mode;
  endsequence
  sequence s_off2;
    O_STATUS.off_mode && $past(O_STATUS.off_mode);
  endsequence

  property p_wr;
    s_wr |-> O_INPUT_LOCKOUT_LEVEL ==
      (($past(I_LEVEL_WDATA) > 4'ha) ? 4'ha : $past(I_LEVEL_WDATA));
  endproperty
  a_wr: assert property (p_wr) else $error("level write mismatch");
  property p_mv;
    O_LOCKOUT_MV == 14'h1194 + 14'h0190 * O_INPUT_LOCKOUT_LEVEL;
  endproperty
  a_mv: assert property (p_mv) else $error("threshold mismatch");
  property p_off;
    s_off2 |-> !O_ALERT_OE && !O_CONVERTER_EN && O_INPUT_LOCKOUT_LEVEL == 4'h7;
  endproperty
  a_off: assert property (p_off) else $error("off mode not quiet");
  property p_od;
    O_ALERT_OUT == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("alert data not low");
  property p_done;
    $rose(O_STATUS.powered_up) |-> O_ALERT_OE && $past(O_STATUS.starting, 8);
  endproperty
  a_done: assert property (p_done) else $error("power-up done wrong");
  property p_gate;
    O_CONVERTER_EN |-> $past(I_CONVERTER_REQ) && !$past(O_STATUS.off_mode);
  endproperty
  a_gate: assert property (p_gate) else $error("converter on unasked");
  property p_uv;
    O_STATUS.lockout && $past(O_STATUS.lockout) |-> !O_CONVERTER_EN;
  endproperty
  a_uv: assert property (p_uv) else $error("converter on in lockout");
  property p_blank;
    $rose(O_STATUS.lockout) |-> below_run >= BLANK_CYCLES;
  endproperty
  a_blank: assert property (p_blank) else $error("lockout too early");
  property p_rel;
    (!I_SUPPLY_BELOW_LEVEL) [*7] |-> !O_STATUS.lockout;
  endproperty
  a_rel: assert property (p_rel) else $error("lockout not released");
  property p_set;
    $rose(O_ALERT_OE) |-> O_STATUS.powered_up;
  endproperty
  a_set: assert property (p_set) else $error("alert without power-up done");
  property p_clr;
    $fell(O_ALERT_OE) |-> $past(I_ALERT_CLEAR) || $past(O_STATUS.off_mode);
  endproperty
  a_clr: assert property (p_clr) else $error("alert dropped unasked");
endmodule : pue_top_sva

bind pue_top pue_top_sva #(.BLANK_CYCLES(BLANK_CYCLES)) pue_top_sva_i (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SUPPLY_BELOW_LEVEL(I_SUPPLY_BELOW_LEVEL),
  .I_LEVEL_WR(I_LEVEL_WR), .I_LEVEL_WDATA(I_LEVEL_WDATA), .I_CONVERTER_REQ(I_CONVERTER_REQ),
  .I_ALERT_CLEAR(I_ALERT_CLEAR),
  .O_ALERT_OUT(O_ALERT_OUT), .O_ALERT_OE(O_ALERT_OE), .O_STATUS(O_STATUS),
  .O_INPUT_LOCKOUT_LEVEL(O_INPUT_LOCKOUT_LEVEL), .O_LOCKOUT_MV(O_LOCKOUT_MV),
  .O_CONVERTER_EN(O_CONVERTER_EN));

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the power-up sequencer
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned BLANK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic sup_ok = 1'b0;
  logic below = 1'b1;
  logic conv_req = 1'b0;
  logic lvl_wr, alert_clr, alert_out, alert_oe, conv_en;
  logic [3:0] lvl_wdata, level;
  logic [13:0] mv;
  pue_pkg::pue_status_t status;
  wire logic alert_n;
  int err_count = 0;
  int n_checks = 0;

  // Clock and pulled-up open-drain alert line
  always #4 clk = ~clk;
  assign alert_n = alert_oe ? alert_out : 1'b1;

  pue_top #(.BLANK_CYCLES(BLANK)) pue_top_i (
    .I_REF_CLK(clk), .I_RST(rst), .I_HIGH_VOLTAGE_ENABLE_IN(en),
    .I_SUPPLY_VALID(sup_ok), .I_SUPPLY_BELOW_LEVEL(below), .I_LEVEL_WR(lvl_wr),
    .I_LEVEL_WDATA(lvl_wdata), .I_ALERT_CLEAR(alert_clr), .I_CONVERTER_REQ(conv_req),
    .O_ALERT_OUT(alert_out), .O_ALERT_OE(alert_oe), .O_INPUT_LOCKOUT_LEVEL(level),
    .O_LOCKOUT_MV(mv), .O_CONVERTER_EN(conv_en), .O_STATUS(status));
  pue_master_model pue_master_model_i (
    .i_clk(clk), .o_level_wr(lvl_wr), .o_level_wdata(lvl_wdata), .o_alert_clear(alert_clr));

  // Compare, count and report
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task summarize;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Bounded wait for a level on the alert line or on lockout status
  task wait_on(input bit use_lock, input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim && (use_lock ? status.lockout : alert_n) !== lvl; k++) cyc(1);
    if (k == lim)
    begin
      $display("[FAIL] t=%0t wait timed out got=%h exp=%h", $time,
        (use_lock ? status.lockout : alert_n), lvl);
      err_count++;
      summarize();
    end
  endtask : wait_on

  // Off mode refuses writes and shows defaults
  task t_off;
    chk(16'(mv), 16'h1c84);
    sup_ok = 1'b1;
    below = 1'b0;
    pue_master_model_i.write_level(4'h3);
    cyc(10);
    chk(16'(status), 16'h0008);
    chk(16'(level), 16'h0007);
    chk(16'(alert_n), 16'h0001);
  endtask : t_off
  // Enable without a valid supply stays waiting, then power-up completes
  task t_power_up;
    sup_ok = 1'b0;
    en = 1'b1;
    cyc(40);
    chk(16'(status), 16'h0000);
    sup_ok = 1'b1;
    wait_on(1'b0, 1'b0, 100);
    chk(16'(status), 16'h0002);
    chk(16'(alert_out), 16'h0000);
    conv_req = 1'b1;
    cyc(2);
    chk(16'(conv_en), 16'h0001);
  endtask : t_power_up
  // Every code, saturation above ten
  task t_levels;
    int e;
    for (int c = 0; c < 16; c++)
    begin
      e = (c > 10) ? 10 : c;
      pue_master_model_i.write_level(4'(c));
      cyc(1);
      chk(16'(level), 16'(e));
      chk(16'(mv), 16'(4500 + 400 * e));
    end
  endtask : t_levels
  // Short dip ignored, long dip locks the converter out, recovery releases it
  task t_lockout;
    below = 1'b1;
    cyc(BLANK - 6);
    below = 1'b0;
    cyc(10);
    chk(16'(status.lockout), 16'h0000);
    chk(16'(conv_en), 16'h0001);
    below = 1'b1;
    cyc(BLANK - 6);
    chk(16'(status.lockout), 16'h0000);
    wait_on(1'b1, 1'b1, BLANK + 20);
    cyc(1);
    chk(16'(conv_en), 16'h0000);
    chk(16'(status.powered_up), 16'h0001);
    below = 1'b0;
    cyc(8);
    chk(16'(status.lockout), 16'h0000);
    chk(16'(conv_en), 16'h0001);
  endtask : t_lockout
  // Acknowledge, then disable back to Off
  task t_clear_off;
    pue_master_model_i.clear_alert();
    cyc(1);
    chk(16'(alert_n), 16'h0001);
    en = 1'b0;
    cyc(10);
    chk(16'(status), 16'h0008);
    chk(16'(level), 16'h0007);
    chk(16'(conv_en), 16'h0000);
  endtask : t_clear_off

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(1);
    t_off();
    t_power_up();
    t_levels();
    t_lockout();
    t_clear_off();
    summarize();
  end
endmodule : tb

`default_nettype wire
